/* File: hw/timebase_gpio_defs.vh */
// Constants for the timebase divider and general purpose pin block.
// How it works
// - Clock input held at ground selects the internal oscillator as timebase.
// - A 4MHz crystal between clock input and crystal drive pin is supported.
// - External clocks from 250kHz to 15.5MHz are accepted on the clock input.
// - External clock is divided by twice the divisor register bits 0-4.
// - Code 00000 passes the clock undivided; code 01000 divides by sixteen.
// - Pin configuration bits 5-4 select the mode of pin one.
// - Pin configuration bit 1 pulls pin two low on pass transistor stress.
// - Pin three pulls low when configuration bit 7 is set, else floats.
// - With alert enables cleared, alert control bit 6 pulls the alert pin low.
// - Alert control bit 7 pulls alert low and joins the alert response protocol.
// - All three pins and the alert pin are compared against 1.28V always.
// - The four comparator results read in status second byte bits 4-7.
// - With alert control bit 7 set, answer address 0x19 with own address, then clear bit 7.
`ifndef TIMEBASE_GPIO_DEFS_VH
`define TIMEBASE_GPIO_DEFS_VH

`define REG_PIN_CFG 8'h07
`define REG_TB_DIV 8'h10
`define REG_ALERT_CTL 8'h1c
`define REG_STATUS 8'h1f
`define PIN_CFG_RESET 8'h40
`define TB_DIV_RESET 8'h00
`define ALERT_CTL_RESET 8'h00
`define DIV_LSB 0
`define DIV_MSB 4
`define IO1_MODE_MSB 5
`define IO1_MODE_LSB 4
`define IO1_MODE_LOW 2'h2
`define IO2_STRESS_BIT 1
`define IO2_HIGH_BIT 6
`define IO3_LOW_BIT 7
`define ALERT_GPIO_BIT 6
`define ALERT_ARP_BIT 7
`define ARA_BYTE 8'h19
`define DEV_ADDR_DEFAULT 7'h50
`define CLK_PERIOD_NS 50
`define TB_TARGET_KHZ 250
`define INT_HALF_CYC (500000 / `TB_TARGET_KHZ / `CLK_PERIOD_NS)
`define GROUND_CYC (2000000 / `TB_TARGET_KHZ / `CLK_PERIOD_NS)

`endif

/* File: hw/timebase_divider.v */
// Timebase source selection and glitch-free even divider.
`timescale 1ns/100ps
`default_nettype none
`include "timebase_gpio_defs.vh"
module timebase_divider #(
   parameter IDLE_W = 8
) (
   input wire mclk,
   input wire resetn,
   input wire clkPinSync,
   input wire [4:0] divisor,
   output reg timebaseClk_q,
   output reg timebaseTick_q,
   output reg useInternal_q
);
   localparam integer GROUND_LAST_I = `GROUND_CYC - 1;
   localparam integer INT_LAST_I = `INT_HALF_CYC - 1;
   localparam [IDLE_W-1:0] GROUND_LAST = GROUND_LAST_I[IDLE_W-1:0];
   localparam [5:0] INT_LAST = INT_LAST_I[5:0];
   localparam [4:0] ONE = 5'h01;

   reg clkPrev_q;
   reg [4:0] edgeCnt_q;
   reg [4:0] edgeCnt_d;
   reg [IDLE_W-1:0] idleCnt_q;
   reg [5:0] intCnt_q;
   reg [5:0] intCnt_d;
   reg timebaseClk_d;
   wire extRise = clkPinSync & ~clkPrev_q;
   wire extEdge = clkPinSync ^ clkPrev_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Next divided level; the output only ever changes from this flop.
   always @* begin
      timebaseClk_d = timebaseClk_q;
      edgeCnt_d = edgeCnt_q;
      intCnt_d = 6'h00;
      if (useInternal_q) begin
         intCnt_d = intCnt_q + 6'h01;
         if (intCnt_q >= INT_LAST) begin
            intCnt_d = 6'h00;
            timebaseClk_d = ~timebaseClk_q;
         end
      end else if (divisor == 5'h00) begin
         timebaseClk_d = clkPinSync;
         edgeCnt_d = 5'h00;
      end else if (extRise) begin
         if (edgeCnt_q >= divisor - ONE) begin
            edgeCnt_d = 5'h00;
            timebaseClk_d = ~timebaseClk_q;
         end else begin
            edgeCnt_d = edgeCnt_q + ONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Source detection and output flops.
   always @(posedge mclk) begin
      if (!resetn) begin
         clkPrev_q <= 1'b0;
         edgeCnt_q <= 5'h00;
         idleCnt_q <= {IDLE_W{1'b0}};
         intCnt_q <= 6'h00;
         useInternal_q <= 1'b0;
         timebaseClk_q <= 1'b0;
         timebaseTick_q <= 1'b0;
      end else begin
         clkPrev_q <= clkPinSync;
         edgeCnt_q <= edgeCnt_d;
         intCnt_q <= intCnt_d;
         timebaseClk_q <= timebaseClk_d;
         timebaseTick_q <= timebaseClk_d & ~timebaseClk_q;
         if (extEdge) begin
            idleCnt_q <= {IDLE_W{1'b0}};
            useInternal_q <= 1'b0;
         end else if (idleCnt_q >= GROUND_LAST) begin
            useInternal_q <= ~clkPinSync;
         end else begin
            idleCnt_q <= idleCnt_q + {{(IDLE_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // timebase_divider
`default_nettype wire

/* File: hw/timebase_gpio_config.v */
// Two-wire register slave, pin configuration and timebase for the controller.
`timescale 1ns/100ps
`default_nettype none
`include "timebase_gpio_defs.vh"
module timebase_gpio_config #(
   parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
   input wire mclk,
   input wire resetn,
   input wire sclIn,
   input wire sdaIn,
   output wire sdaOut,
   output reg sdaOe_q,
   input wire alertIn,
   output wire alertOut,
   output reg alertOe_q,
   input wire ioPinOneIn,
   output wire ioPinOneOut,
   output reg ioPinOneOe_q,
   input wire ioPinTwoIn,
   output wire ioPinTwoOut,
   output reg ioPinTwoOe_q,
   input wire ioPinThreeIn,
   output wire ioPinThreeOut,
   output reg ioPinThreeOe_q,
   input wire fetStress,
   input wire clockInputPin,
   output reg crystalDrivePin_q,
   output wire timebaseClk,
   output wire timebaseTick,
   output wire timebaseInternal,
   output reg [2:0] divisorUpper_q
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RECV = 3'h1;
   localparam [2:0] ST_ACK = 3'h2;
   localparam [2:0] ST_SEND = 3'h3;
   localparam [2:0] ST_MACK = 3'h4;
   localparam [1:0] K_ADDR = 2'h0;
   localparam [1:0] K_CMD = 2'h1;
   localparam [1:0] K_DATA = 2'h2;

   reg zero_q;
   reg [6:0] syncA_q;
   reg [6:0] syncB_q;
   reg sclP_q;
   reg sdaP_q;
   reg [2:0] state_q;
   reg [3:0] bitCnt_q;
   reg [7:0] shift_q;
   reg [1:0] kind_q;
   reg read_q;
   reg ara_q;
   reg [7:0] ptr_q;
   reg byteSel_q;
   reg [7:0] tx_q;
   reg [7:0] pinCfg_q;
   reg [7:0] tbDiv_q;
   reg [7:0] alertCtl_q;
   reg [7:0] rdData;
   wire [7:0] txNext;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin inputs pass two flops; only the second stage is read by logic.
   wire sclS = syncB_q[0];
   wire sdaS = syncB_q[1];
   wire clkS = syncB_q[2];
   wire [3:0] cmpS = syncB_q[6:3];
   wire sclRise = sclS & ~sclP_q;
   wire sclFall = ~sclS & sclP_q;
   wire busStart = sclS & sclP_q & sdaP_q & ~sdaS;
   wire busStop = sclS & sclP_q & ~sdaP_q & sdaS;

   always @(posedge mclk) begin
      if (!resetn) begin
         syncA_q <= 7'h03;
         syncB_q <= 7'h03;
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
         zero_q <= 1'b0;
         crystalDrivePin_q <= 1'b0;
      end else begin
         syncA_q <= {alertIn, ioPinThreeIn, ioPinTwoIn, ioPinOneIn,
                     clockInputPin, sdaIn, sclIn};
         syncB_q <= syncA_q;
         sclP_q <= sclS;
         sdaP_q <= sdaS;
         zero_q <= 1'b0;
         crystalDrivePin_q <= ~clkS;
      end
   end

   assign sdaOut = zero_q;
   assign alertOut = zero_q;
   assign ioPinOneOut = zero_q;
   assign ioPinTwoOut = zero_q;
   assign ioPinThreeOut = zero_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data for the current pointer.
   always @* begin
      case (ptr_q)
         `REG_PIN_CFG: rdData = pinCfg_q;
         `REG_TB_DIV: rdData = tbDiv_q;
         `REG_ALERT_CTL: rdData = alertCtl_q;
         `REG_STATUS: rdData = byteSel_q ? {cmpS, 4'h0} : 8'h00;
         default: rdData = 8'h00;
      endcase
   end

   assign txNext = ara_q ? {DEV_ADDR, 1'b0} : rdData;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial slave and register file.
   always @(posedge mclk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         kind_q <= K_ADDR;
         read_q <= 1'b0;
         ara_q <= 1'b0;
         ptr_q <= 8'h00;
         byteSel_q <= 1'b0;
         tx_q <= 8'h00;
         sdaOe_q <= 1'b0;
         pinCfg_q <= `PIN_CFG_RESET;
         tbDiv_q <= `TB_DIV_RESET;
         alertCtl_q <= `ALERT_CTL_RESET;
      end else if (busStart) begin
         state_q <= ST_RECV;
         bitCnt_q <= 4'h0;
         kind_q <= K_ADDR;
         ara_q <= 1'b0;
         sdaOe_q <= 1'b0;
      end else if (busStop) begin
         state_q <= ST_IDLE;
         sdaOe_q <= 1'b0;
      end else begin
         case (state_q)
            ST_RECV: begin
               if (sclRise && bitCnt_q != 4'h8) begin
                  shift_q <= {shift_q[6:0], sdaS};
                  bitCnt_q <= bitCnt_q + 4'h1;
               end
               if (sclFall && bitCnt_q == 4'h8) begin
                  bitCnt_q <= 4'h0;
                  case (kind_q)
                     K_ADDR: begin
                        if (shift_q[7:1] == DEV_ADDR) begin
                           read_q <= shift_q[0];
                           kind_q <= K_CMD;
                           sdaOe_q <= 1'b1;
                           state_q <= ST_ACK;
                        end else if (shift_q == `ARA_BYTE && alertCtl_q[`ALERT_ARP_BIT]) begin
                           read_q <= 1'b1;
                           ara_q <= 1'b1;
                           sdaOe_q <= 1'b1;
                           state_q <= ST_ACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end
                     K_CMD: begin
                        ptr_q <= shift_q;
                        byteSel_q <= 1'b0;
                        kind_q <= K_DATA;
                        sdaOe_q <= 1'b1;
                        state_q <= ST_ACK;
                     end
                     default: begin
                        case (ptr_q)
                           `REG_PIN_CFG: pinCfg_q <= shift_q;
                           `REG_TB_DIV: tbDiv_q <= shift_q;
                           `REG_ALERT_CTL: alertCtl_q <= shift_q;
                           default: ;
                        endcase
                        if (ptr_q == `REG_STATUS && !byteSel_q) begin
                           byteSel_q <= 1'b1;
                        end else begin
                           ptr_q <= ptr_q + 8'h01;
                           byteSel_q <= 1'b0;
                        end
                        sdaOe_q <= 1'b1;
                        state_q <= ST_ACK;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  if (read_q) begin
                     tx_q <= txNext;
                     sdaOe_q <= ~txNext[7];
                     state_q <= ST_SEND;
                  end else begin
                     sdaOe_q <= 1'b0;
                     state_q <= ST_RECV;
                  end
               end
            end
            ST_SEND: begin
               if (sclFall) begin
                  if (bitCnt_q == 4'h7) begin
                     bitCnt_q <= 4'h0;
                     sdaOe_q <= 1'b0;
                     state_q <= ST_MACK;
                     if (ara_q) begin
                        alertCtl_q[`ALERT_ARP_BIT] <= 1'b0;
                     end
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     sdaOe_q <= ~tx_q[6];
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (sclRise) begin
                  if (sdaS) begin
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_ACK;
                     if (!ara_q) begin
                        if (ptr_q == `REG_STATUS && !byteSel_q) begin
                           byteSel_q <= 1'b1;
                        end else begin
                           ptr_q <= ptr_q + 8'h01;
                           byteSel_q <= 1'b0;
                        end
                     end
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers; each enable pulls its pin low.
   always @(posedge mclk) begin
      if (!resetn) begin
         ioPinOneOe_q <= 1'b0;
         ioPinTwoOe_q <= 1'b0;
         ioPinThreeOe_q <= 1'b0;
         alertOe_q <= 1'b0;
         divisorUpper_q <= 3'h0;
      end else begin
         ioPinOneOe_q <= pinCfg_q[`IO1_MODE_MSB:`IO1_MODE_LSB] == `IO1_MODE_LOW;
         ioPinTwoOe_q <= (pinCfg_q[`IO2_STRESS_BIT] & fetStress)
                         | ~pinCfg_q[`IO2_HIGH_BIT];
         ioPinThreeOe_q <= pinCfg_q[`IO3_LOW_BIT];
         alertOe_q <= alertCtl_q[`ALERT_GPIO_BIT]
                      | alertCtl_q[`ALERT_ARP_BIT];
         divisorUpper_q <= tbDiv_q[7:5];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timebase.
   timebase_divider u_divider (
      .mclk(mclk),
      .resetn(resetn),
      .clkPinSync(clkS),
      .divisor(tbDiv_q[`DIV_MSB:`DIV_LSB]),
      .timebaseClk_q(timebaseClk),
      .timebaseTick_q(timebaseTick),
      .useInternal_q(timebaseInternal)
   );
endmodule // timebase_gpio_config
`default_nettype wire

/* File: test/pin_board_model.sv */
// Board model: pull-ups on the open-drain pins and the serial data line.
`timescale 1ns/100ps
`default_nettype none
module pin_board_model (
   input wire logic [3:0] pinOe,
   input wire logic [3:0] extLow,
   output logic [3:0] pinLevel,
   input wire logic sdaSlaveOe,
   input wire logic sdaMasterLow,
   output logic sdaLevel
);
   // Comparators see the wire even while the device pulls it.
   assign pinLevel = ~(pinOe | extLow);
   assign sdaLevel = ~(sdaSlaveOe | sdaMasterLow);
endmodule // pin_board_model
`default_nettype wire

/* File: test/timebase_gpio_config_assertions.sv */
// Assertion checker bound to the timebase and pin configuration block.
`timescale 1ns/100ps
`default_nettype none
module timebase_gpio_config_checker (
   input wire mclk,
   input wire resetn,
   input wire sclIn,
   input wire sdaOut,
   input wire sdaOe_q,
   input wire alertOut,
   input wire alertOe_q,
   input wire ioPinOneOut,
   input wire ioPinOneOe_q,
   input wire ioPinTwoOut,
   input wire ioPinTwoOe_q,
   input wire ioPinThreeOut,
   input wire ioPinThreeOe_q,
   input wire clockInputPin,
   input wire crystalDrivePin_q,
   input wire timebaseClk,
   input wire timebaseTick,
   input wire timebaseInternal
);
   logic prevClk_q;
   logic [7:0] sinceEdge_q;
   logic [7:0] intRun_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   always @(posedge mclk) begin
      prevClk_q <= timebaseClk;
      if (!resetn || timebaseClk != prevClk_q) begin
         sinceEdge_q <= 8'h00;
      end else if (sinceEdge_q != 8'hff) begin
         sinceEdge_q <= sinceEdge_q + 8'h01;
      end
      if (!resetn || !timebaseInternal) begin
         intRun_q <= 8'h00;
      end else if (intRun_q != 8'hff) begin
         intRun_q <= intRun_q + 8'h01;
      end
   end
   chk_pins_pull_low: assert property (!sdaOut && !ioPinOneOut && !ioPinTwoOut
      && !ioPinThreeOut && !alertOut) else $error("A pin drives high.");
   chk_reset_released: assert property (disable iff (1'b0) !resetn |=>
      !ioPinOneOe_q && !ioPinTwoOe_q && !ioPinThreeOe_q && !alertOe_q)
      else $error("A pin is pulled after reset.");
   chk_tick_on_rise: assert property ($rose(timebaseClk) |-> ##[0:1] timebaseTick)
      else $error("Timebase rise gives no tick.");
   chk_tick_single: assert property (timebaseTick |=> !timebaseTick)
      else $error("Tick lasts more than one cycle.");
   chk_int_period: assert property ((timebaseInternal
      && intRun_q > {1'b0, sinceEdge_q} + 9'h002 && timebaseClk != prevClk_q)
      |-> sinceEdge_q == 8'h27) else $error("Internal timebase half period is wrong.");
   chk_int_grounded: assert property ($rose(timebaseInternal) |-> !clockInputPin)
      else $error("Internal source chosen with clock pin high.");
   chk_ext_return: assert property ($changed(clockInputPin) |-> ##[1:8] !timebaseInternal)
      else $error("Clock pin edge does not select external source.");
   chk_crystal_drive: assert property ($stable(clockInputPin)[*5]
      |-> crystalDrivePin_q != clockInputPin) else $error("Crystal drive not inverted.");
   chk_data_scl_low: assert property ($changed(sdaOe_q) |-> !sclIn)
      else $error("Data line changes while bus clock high.");
   cover property ($rose(timebaseInternal));
   cover property ($rose(alertOe_q));
   cover property ($rose(ioPinThreeOe_q));
endmodule // timebase_gpio_config_checker
bind timebase_gpio_config timebase_gpio_config_checker checkU (.mclk(mclk), .resetn(resetn),
   .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe_q(sdaOe_q), .alertOut(alertOut),
   .alertOe_q(alertOe_q),
   .ioPinOneOut(ioPinOneOut), .ioPinOneOe_q(ioPinOneOe_q), .ioPinTwoOut(ioPinTwoOut),
   .ioPinTwoOe_q(ioPinTwoOe_q), .ioPinThreeOut(ioPinThreeOut),
   .ioPinThreeOe_q(ioPinThreeOe_q), .clockInputPin(clockInputPin),
   .crystalDrivePin_q(crystalDrivePin_q), .timebaseClk(timebaseClk),
   .timebaseTick(timebaseTick), .timebaseInternal(timebaseInternal));
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the timebase and pin configuration block.
`timescale 1ns/100ps
`default_nettype none
`include "timebase_gpio_defs.vh"
`define CHECK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin fail_count++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module testbench;
   logic mclk, resetn, scl, sdaLow, fetStress, clkPin, clkRun, sdaLvl, sdaOe;
   logic alertOe, oneOe, twoOe, threeOe, tbTick, tbInt;
   logic [3:0] extLow, pinLvl;
   logic [2:0] divUp;
   logic [7:0] r;
   logic [15:0] d;
   logic n, n2;
   int fail_count, comparisons, per;
   localparam logic [7:0] AW = {`DEV_ADDR_DEFAULT, 1'b0};
   timebase_gpio_config dut_u (.mclk(mclk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLvl),
      .sdaOut(), .sdaOe_q(sdaOe), .alertIn(pinLvl[3]), .alertOut(), .alertOe_q(alertOe),
      .ioPinOneIn(pinLvl[0]), .ioPinOneOut(), .ioPinOneOe_q(oneOe), .ioPinTwoIn(pinLvl[1]),
      .ioPinTwoOut(), .ioPinTwoOe_q(twoOe), .ioPinThreeIn(pinLvl[2]), .ioPinThreeOut(),
      .ioPinThreeOe_q(threeOe), .fetStress(fetStress), .clockInputPin(clkPin),
      .crystalDrivePin_q(), .timebaseClk(), .timebaseTick(tbTick), .timebaseInternal(tbInt),
      .divisorUpper_q(divUp));
   pin_board_model boardU (.pinOe({alertOe, threeOe, twoOe, oneOe}), .extLow(extLow),
      .pinLevel(pinLvl), .sdaSlaveOe(sdaOe), .sdaMasterLow(sdaLow), .sdaLevel(sdaLvl));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // External clock of eight mclk periods; held low while stopped.
   initial begin
      clkPin = 1'b0;
      forever begin
         @(negedge mclk);
         if (clkRun) begin
            repeat (3) @(negedge mclk);
            clkPin = ~clkPin;
         end else begin
            clkPin = 1'b0;
         end
      end
   end
   task q(input int c);
      repeat (c) @(negedge mclk);
   endtask
   task close_out;
      $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic waitTick(output int c);
      c = 0;
      do begin
         q(1);
         c++;
         if (c > 400) begin
            fail_count++;
            close_out;
         end
      end while (tbTick !== 1'b1);
   endtask
   task automatic bitx(input logic b, output logic rb);
      scl = 1'b0;
      q(4);
      sdaLow = !b;
      q(4);
      scl = 1'b1;
      q(4);
      rb = sdaLvl;
      q(4);
   endtask
   task automatic xb(input logic [7:0] dt, input logic nine, output logic [7:0] rd,
      output logic ak);
      for (int i = 7; i >= 0; i--) bitx(dt[i], rd[i]);
      bitx(nine, ak);
   endtask
   task st;
      scl = 1'b0;
      q(8);
      sdaLow = 1'b0;
      scl = 1'b1;
      q(8);
      sdaLow = 1'b1;
      q(8);
   endtask
   task sp;
      scl = 1'b0;
      q(4);
      sdaLow = 1'b1;
      q(4);
      scl = 1'b1;
      q(8);
      sdaLow = 1'b0;
      q(8);
   endtask
   task wr(input logic [7:0] off, input logic [7:0] dt);
      st;
      xb(AW, 1'b1, r, n);
      xb(off, 1'b1, r, n2);
      n = n | n2;
      xb(dt, 1'b1, r, n2);
      sp;
      `CHECK("write ack", 1'b0, n | n2)
      q(2);
   endtask
   task rdw(input logic [7:0] off);
      st;
      xb(AW, 1'b1, r, n);
      xb(off, 1'b1, r, n);
      st;
      xb(AW | 8'h01, 1'b1, r, n);
      xb(8'hff, 1'b0, d[15:8], n);
      xb(8'hff, 1'b1, d[7:0], n);
      sp;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      `CHECK("pin two after reset", 1'b0, twoOe)
      rdw(`REG_PIN_CFG);
      `CHECK("config reset", 8'h40, d[15:8])
      rdw(`REG_TB_DIV);
      `CHECK("divisor reset", 8'h00, d[15:8])
      rdw(`REG_ALERT_CTL);
      `CHECK("alert reset", 8'h00, d[15:8])
   endtask
   task t_pins;
      for (int m = 0; m < 4; m++) begin
         wr(`REG_PIN_CFG, 8'h40 | 8'(m << 4));
         `CHECK("pin one mode", logic'(m == 2), oneOe)
      end
      wr(`REG_PIN_CFG, 8'h42);
      fetStress = 1'b1;
      q(2);
      `CHECK("pin two stress", 1'b1, twoOe)
      fetStress = 1'b0;
      q(2);
      `CHECK("pin two calm", 1'b0, twoOe)
      wr(`REG_PIN_CFG, 8'h00);
      `CHECK("pin two bit six low", 1'b1, twoOe)
      `CHECK("pin three off", 1'b0, threeOe)
      wr(`REG_PIN_CFG, 8'hc0);
      `CHECK("pin three on", 1'b1, threeOe)
      extLow = 4'h1;
      rdw(`REG_STATUS);
      `CHECK("comparators", 16'h00a0, d)
      extLow = 4'h0;
   endtask
   task t_alert;
      wr(`REG_ALERT_CTL, 8'h40);
      `CHECK("alert plain low", 1'b1, alertOe)
      st;
      xb(`ARA_BYTE, 1'b1, r, n);
      sp;
      `CHECK("no response on bit six", 1'b1, n)
      `CHECK("alert kept", 1'b1, alertOe)
      wr(`REG_ALERT_CTL, 8'h00);
      `CHECK("alert released", 1'b0, alertOe)
      wr(`REG_ALERT_CTL, 8'h80);
      `CHECK("alert protocol low", 1'b1, alertOe)
      st;
      xb(`ARA_BYTE, 1'b1, r, n);
      xb(8'hff, 1'b1, r, n2);
      sp;
      `CHECK("response ack", 1'b0, n)
      `CHECK("response address", AW, r)
      `CHECK("alert after response", 1'b0, alertOe)
   endtask
   task t_divider;
      logic [7:0] codes [4];
      codes = '{8'h00, 8'h01, 8'h03, 8'h08};
      wr(`REG_TB_DIV, 8'he3);
      `CHECK("upper divisor bits", 3'b111, divUp)
      rdw(`REG_TB_DIV);
      `CHECK("divisor readback", 8'he3, d[15:8])
      clkRun = 1'b1;
      foreach (codes[k]) begin
         wr(`REG_TB_DIV, 8'ha0 | codes[k]);
         waitTick(per);
         waitTick(per);
         waitTick(per);
         `CHECK("timebase period", (codes[k] == 0) ? 8 : 16 * codes[k], per)
      end
   endtask
   task t_internal;
      clkRun = 1'b0;
      for (int w = 0; w < 400 && tbInt !== 1'b1; w++) q(1);
      `CHECK("internal chosen", 1'b1, tbInt)
      waitTick(per);
      waitTick(per);
      `CHECK("internal period", 80, per)
      clkRun = 1'b1;
      q(16);
      `CHECK("external again", 1'b0, tbInt)
   endtask
   initial begin
      fail_count = 0;
      comparisons = 0;
      resetn = 1'b0;
      scl = 1'b1;
      sdaLow = 1'b0;
      fetStress = 1'b0;
      clkRun = 1'b0;
      extLow = 4'h0;
      q(10);
      resetn = 1'b1;
      q(4);
      t_reset;
      t_pins;
      t_alert;
      t_divider;
      t_internal;
      close_out;
   end
endmodule // testbench
`default_nettype wire
